// ### design/scpm_clk_gen.sv
// Card clock enable generator: run, stopped, or divided by sixteen
`timescale 1ns/100ps
`default_nettype none
module scpm_clk_gen
    import scpm_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                global_reset_n,
    input  wire scpm_pkg::scpm_clk_e mode,
    output logic                     card_clk_en
);
    import scpm_pkg::*;
    logic [3:0] div_reg;
    wire        div_wrap = (div_reg == SCPM_DIV_LAST);

    // Divider and enable pulse for the card clock
    always_ff @(posedge hclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            div_reg     <= 4'h0;
            card_clk_en <= 1'b0;
        end else begin
            div_reg     <= div_wrap ? 4'h0 : div_reg + 4'h1;
            unique case (mode)
                SCPM_CLK_RUN:     card_clk_en <= 1'b1;
                SCPM_CLK_STOPPED: card_clk_en <= 1'b0;
                SCPM_CLK_SLOW:    card_clk_en <= div_wrap;
                default:          card_clk_en <= 1'b1;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### design/scpm_pkg.sv
// Package: register map, field positions and timing constants for socket clock power management
package scpm_pkg;
    localparam logic [7:0]  SCPM_PWR_MGMT_OFFSET = 8'h20;
    localparam logic [31:0] SCPM_PWR_MGMT_RESET  = 32'h00000000;
    localparam int          SCPM_ACCESS_BIT      = 25;
    localparam int          SCPM_RATE_BIT        = 24;
    localparam int          SCPM_ENABLE_BIT      = 16;
    localparam int          SCPM_SELECT_BIT      = 0;
    localparam int          SCPM_IDLE_CLOCKS     = 8;
    localparam logic [3:0]  SCPM_IDLE_LAST       = 4'(SCPM_IDLE_CLOCKS - 1);
    localparam int          SCPM_SLOW_DIVIDE     = 16;
    localparam logic [3:0]  SCPM_DIV_LAST        = 4'(SCPM_SLOW_DIVIDE - 1);
    typedef enum logic [1:0] {
        SCPM_CLK_RUN,
        SCPM_CLK_STOPPED,
        SCPM_CLK_SLOW
    } scpm_clk_e;
endpackage

// ### design/scpm_top.sv
// Top: AHB-Lite slave with socket power management register and idle clock control
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module scpm_top
    import scpm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        global_reset_pin_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        socket_access,
    input  wire logic        socket_busy,
    input  wire logic        host_clk_stop_ok,
    input  wire logic        host_independent_clock_stop,
    output logic             card_clk_en,
    output logic             card_clk_reduced
);
    import scpm_pkg::*;

    // Registers
    logic        enable_reg;
    logic        select_reg;
    logic        accessed_reg;
    logic        changed_reg;
    logic        wr_pend_reg;
    logic [3:0]  idle_cnt_reg;
    scpm_clk_e   mode_reg;
    scpm_clk_e   mode_next;

    // Address phase decode
    wire         addr_hit  = (haddr == SCPM_PWR_MGMT_OFFSET);
    wire         xfer      = hsel && hready && htrans[1];
    wire         wr_start  = xfer && hwrite && addr_hit;
    wire         rd_start  = xfer && !hwrite && addr_hit;

    // Register read image, unused bits zero
    wire [31:0]  reg_image = ({31'h0, select_reg} << SCPM_SELECT_BIT)
                           | ({31'h0, enable_reg} << SCPM_ENABLE_BIT)
                           | ({31'h0, changed_reg} << SCPM_RATE_BIT)
                           | ({31'h0, accessed_reg} << SCPM_ACCESS_BIT);
    wire [31:0]  rd_next   = rd_start ? reg_image : 32'h0;

    // Idle detection and clock mode selection
    wire         idle_done = (idle_cnt_reg == SCPM_IDLE_LAST);
    wire         host_ok   = host_independent_clock_stop || host_clk_stop_ok;
    wire         may_idle  = enable_reg && idle_done && !socket_busy && host_ok;
    always_comb begin
        if (may_idle && select_reg) begin
            mode_next = SCPM_CLK_SLOW;
        end else if (may_idle) begin
            mode_next = SCPM_CLK_STOPPED;
        end else begin
            mode_next = SCPM_CLK_RUN;
        end
    end

    // Bus response, zero wait state slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= 1'b0;
        end else begin
            if (hready) begin
                hrdata <= rd_next;
            end
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= hready ? wr_start : wr_pend_reg;
        end
    end

    // Control bits on bus reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= 1'b0;
            select_reg <= 1'b0;
        end else if (wr_pend_reg && hready) begin
            enable_reg <= hwdata[SCPM_ENABLE_BIT];
            select_reg <= hwdata[SCPM_SELECT_BIT];
        end
    end

    // Status bits on global reset only; set wins over read clear
    always_ff @(posedge hclk or negedge global_reset_pin_n) begin
        if (!global_reset_pin_n) begin
            accessed_reg <= 1'b0;
            changed_reg  <= 1'b0;
        end else begin
            if (socket_access) begin
                accessed_reg <= 1'b1;
            end else if (rd_start) begin
                accessed_reg <= 1'b0;
            end
            changed_reg <= (mode_next == SCPM_CLK_SLOW);
        end
    end

    // Idle counter and clock mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_reg     <= 4'h0;
            mode_reg         <= SCPM_CLK_RUN;
            card_clk_reduced <= 1'b0;
        end else begin
            if (socket_busy || socket_access) begin
                idle_cnt_reg <= 4'h0;
            end else if (!idle_done) begin
                idle_cnt_reg <= idle_cnt_reg + 4'h1;
            end
            mode_reg         <= mode_next;
            card_clk_reduced <= (mode_next != SCPM_CLK_RUN);
        end
    end

    // Card clock enable generator
    scpm_clk_gen u_clk_gen (
        .hclk           (hclk),
        .global_reset_n (hresetn),
        .mode           (mode_reg),
        .card_clk_en    (card_clk_en)
    );

    // Checks: access flag set by card activity
    chk_access_sets: assert property (
        @(posedge hclk) disable iff (!global_reset_pin_n)
        socket_access |=> accessed_reg
    ) else $error("access flag not set");

    // Checks: register read clears the access flag
    chk_read_clears: assert property (
        @(posedge hclk) disable iff (!global_reset_pin_n)
        rd_start && !socket_access |=> !accessed_reg
    ) else $error("access flag not cleared");

    // Checks: read data carries the flag as it stood before the clear
    chk_read_flag: assert property (
        @(posedge hclk) disable iff (!hresetn || !global_reset_pin_n)
        rd_start |=> hrdata[SCPM_ACCESS_BIT] == $past(accessed_reg)
    ) else $error("read data lost access flag");

    // Checks: rate flag follows slow mode
    chk_rate_flag: assert property (
        @(posedge hclk) disable iff (!hresetn || !global_reset_pin_n)
        changed_reg == (mode_reg == SCPM_CLK_SLOW)
    ) else $error("rate flag mismatch");

    // Checks: no reduction while control is disabled
    chk_disable_runs: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !enable_reg |=> mode_reg == SCPM_CLK_RUN
    ) else $error("clock reduced while disabled");

    // Checks: a bus write lands in the enable bit
    chk_write_lands: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_reg && hready |=> enable_reg == $past(hwdata[SCPM_ENABLE_BIT])
    ) else $error("enable write lost");

    // Checks: run mode gives a running card clock one cycle later
    chk_run_clock: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg == SCPM_CLK_RUN |=> card_clk_en
    ) else $error("card clock missing in run mode");

    // Checks: stopped mode gives no card clock one cycle later
    chk_stop_mode: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg == SCPM_CLK_STOPPED |=> !card_clk_en
    ) else $error("stopped clock ran");

    // Checks: stop mode only with select clear and control enabled
    chk_stop_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg == SCPM_CLK_STOPPED |-> $past(enable_reg) && !$past(select_reg)
    ) else $error("stop without stop select");

    // Checks: slow clock pulses are single cycles
    chk_slow_gap: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(card_clk_en) && mode_reg == SCPM_CLK_SLOW && $past(mode_reg) == SCPM_CLK_SLOW
        |=> !card_clk_en
    ) else $error("slow clock too fast");

    // Checks: slow mode only with select set and control enabled
    chk_slow_select: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg == SCPM_CLK_SLOW |-> $past(enable_reg) && $past(select_reg)
    ) else $error("slow without slow select");

    // Checks: unused bit ranges read zero
    chk_reserved_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hrdata & 32'hFCFEFFFE) == 32'h0
    ) else $error("reserved bits nonzero");

    // Checks: bus reset leaves the status flag alone
    chk_status_hold: assert property (
        @(posedge hclk) disable iff (!global_reset_pin_n)
        $rose(hresetn) && $past(accessed_reg) |-> accessed_reg
    ) else $error("bus reset cleared status");

    // Checks: busy socket keeps the clock running
    chk_idle_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        socket_busy |=> mode_reg == SCPM_CLK_RUN ##1 mode_reg == SCPM_CLK_RUN
    ) else $error("early clock stop");

    // Checks: reduction only after the full idle count
    chk_idle_count: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg != SCPM_CLK_RUN |-> $past(idle_cnt_reg) == SCPM_IDLE_LAST
    ) else $error("reduction before idle count");

    // Checks: reduction only when the host side permits it
    chk_host_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg != SCPM_CLK_RUN |-> $past(host_independent_clock_stop || host_clk_stop_ok)
    ) else $error("reduction without host permission");

    // Checks: rate flag drops when slow mode ends
    chk_rate_restore: assert property (
        @(posedge hclk) disable iff (!hresetn || !global_reset_pin_n)
        $fell(mode_reg == SCPM_CLK_SLOW) |-> !changed_reg
    ) else $error("rate flag stuck");
endmodule
`default_nettype wire

// ### dv/scpm_card_model.sv
// Card-side model: socket activity on request and card clock tick counting
`timescale 1ns/100ps
`default_nettype none
module scpm_card_model (
    input  wire logic hclk,
    input  wire logic card_clk_en,
    input  wire logic do_access,
    output var logic  socket_access,
    output var logic  socket_busy,
    output var int    card_ticks
);
    initial begin
        socket_access = 1'b0;
        socket_busy = 1'b0;
        card_ticks = 0;
    end
    // One access cycle, busy one cycle longer; count enabled card clocks
    always @(posedge hclk) begin
        socket_access <= do_access;
        socket_busy <= do_access | socket_access;
        if (card_clk_en === 1'b1) card_ticks <= card_ticks + 1;
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Testbench: register, access flag, idle clock and reset scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import scpm_pkg::*;
    logic hclk = 0, hresetn = 0, global_reset_pin_n = 0, hsel = 0, hwrite = 0;
    logic do_acc = 0, host_ok = 0, indep = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 0, rd;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, card_clk_en, reduced, sacc, sbusy;
    int card_ticks, t0, fails = 0, checks_done = 0;
    // 20 MHz clock
    always #25 hclk = ~hclk;
    scpm_top scpm_top_inst (.hclk, .hresetn, .global_reset_pin_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .socket_access(sacc), .socket_busy(sbusy),
        .host_clk_stop_ok(host_ok), .host_independent_clock_stop(indep), .card_clk_en,
        .card_clk_reduced(reduced));
    scpm_card_model scpm_card_model_inst (.hclk, .card_clk_en, .do_access(do_acc), .socket_access(sacc),
        .socket_busy(sbusy), .card_ticks);
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Bounded wait for hready high at an edge
    task wrdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        if (n == 50) begin
            fails++;
            print_verdict;
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wrdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy;
        rd = hrdata;
    endtask
    task pulse_access;
        do_acc <= 1'b1;
        cyc(1);
        do_acc <= 1'b0;
        cyc(3);
    endtask
    task t_regs;
        ahb(0, 8'h20, 0); chk(rd, SCPM_PWR_MGMT_RESET);
        ahb(1, 8'h20, 32'hFFFFFFFF); ahb(0, 8'h20, 0); chk(rd, 32'h00010001);
        ahb(1, 8'h24, 32'h1); ahb(0, 8'h24, 0); chk(rd, 32'h0);
        chk({hreadyout, hresp}, 32'h2);
        ahb(1, 8'h20, 0);
        $display("test regs done");
    endtask
    task t_access;
        pulse_access;
        ahb(0, 8'h20, 0); chk(rd, 32'h02000000);
        ahb(0, 8'h20, 0); chk(rd, 32'h0);
        $display("test access done");
    endtask
    task t_modes;
        ahb(1, 8'h20, 32'h00010000); cyc(20); chk(reduced, 0);
        indep <= 1'b1; pulse_access; chk(reduced, 0);
        cyc(20); chk(reduced, 1);
        t0 = card_ticks; cyc(16); chk(card_ticks - t0, 0);
        ahb(0, 8'h20, 0); chk(rd, 32'h02010000);
        ahb(1, 8'h20, 32'h00010001); cyc(20);
        t0 = card_ticks; cyc(32); chk(card_ticks - t0, 2);
        ahb(0, 8'h20, 0); chk(rd, 32'h01010001);
        ahb(1, 8'h20, 0); cyc(4); chk(reduced, 0);
        ahb(0, 8'h20, 0); chk(rd, 32'h0);
        t0 = card_ticks; cyc(8); chk(card_ticks - t0, 8);
        indep <= 1'b0;
        host_ok <= 1'b1;
        ahb(1, 8'h20, 32'h00010000);
        cyc(4);
        chk(reduced, 1);
        host_ok <= 1'b0;
        cyc(2);
        chk(reduced, 0);
        ahb(1, 8'h20, 0);
        $display("test modes done");
    endtask
    task t_resets;
        pulse_access;
        hresetn <= 1'b0; cyc(2); hresetn <= 1'b1; cyc(1);
        ahb(0, 8'h20, 0); chk(rd, 32'h02000000);
        pulse_access;
        global_reset_pin_n <= 1'b0; cyc(2); global_reset_pin_n <= 1'b1; cyc(1);
        ahb(0, 8'h20, 0); chk(rd, 32'h0);
        $display("test resets done");
    endtask
    // Main sequence
    initial begin
        cyc(6);
        hresetn <= 1'b1;
        global_reset_pin_n <= 1'b1;
        cyc(1);
        t_regs;
        t_access;
        t_modes;
        t_resets;
        print_verdict;
    end
endmodule
`default_nettype wire
